// ==== core/dmca_consts.svh ====
// register indices, field positions, reset values and timing counts
`ifndef DMCA_CONSTS_SVH
`define DMCA_CONSTS_SVH
`define DMCA_NCH          8
`define DMCA_IDX_AT1      7'h01
`define DMCA_IDX_AT6      7'h06
`define DMCA_IDX_AT7      7'h10
`define DMCA_IDX_AT8      7'h11
`define DMCA_IDX_MUTE_LO  7'h07
`define DMCA_IDX_DIS_LO   7'h08
`define DMCA_IDX_FMT      7'h09
`define DMCA_IDX_CTL      7'h0A
`define DMCA_IDX_MODE     7'h0D
`define DMCA_IDX_MUTE_HI  7'h12
`define DMCA_IDX_DIS_HI   7'h13
`define DMCA_IDX_STAT     7'h20
`define DMCA_IDX_MASK     7'h21
`define DMCA_IDX_APPL     7'h22
`define DMCA_AT_RST       8'hFF
`define DMCA_AT_FULL      8'hFF
`define DMCA_THR_FINE     8'h80
`define DMCA_THR_WIDE     8'h9A
`define DMCA_FMT_RST      3'h5
`define DMCA_BIT_FLT      5
`define DMCA_BIT_SOFT_RESET_BIT     7
`define DMCA_BIT_ZERO_FLAG_POLARITY     6
`define DMCA_BIT_OUTPUT_PHASE_INVERT     5
`define DMCA_MSB_DMF      4
`define DMCA_LSB_DMF      3
`define DMCA_BIT_DMC      0
`define DMCA_BIT_ATTENUATION_MODE_SELECT     7
`define DMCA_SOFT_RESET_BIT_CYC     11'h400
`define DMCA_RAMP_LAST    3'h7
`endif

// ==== core/dmca_pkg.sv ====
// types shared by the mode control and attenuator block
package dmca_pkg;
   typedef enum logic [2:0] {
      DMCA_RJ24 = 3'b000,
      DMCA_RJ20 = 3'b001,
      DMCA_RJ18 = 3'b010,
      DMCA_RJ16 = 3'b011,
      DMCA_I2S  = 3'b100,
      DMCA_LJ   = 3'b101,
      DMCA_RSV6 = 3'b110,
      DMCA_RSV7 = 3'b111
   } dmca_fmt_t;
   typedef enum logic [1:0] {
      DMCA_DE_441 = 2'b00,
      DMCA_DE_48  = 2'b01,
      DMCA_DE_32  = 2'b10,
      DMCA_DE_RSV = 2'b11
   } dmca_de_t;
   typedef enum logic {
      DMCA_RUN  = 1'b0,
      DMCA_SOFT_RESET_BIT = 1'b1
   } dmca_rst_st_t;
endpackage

// ==== core/dmca_top.sv ====
// mode control registers and eight channel ramped attenuator
`timescale 1ns/1ps
`default_nettype none
`include "dmca_consts.svh"
//
// Contract
// - attenuation in dB is step times (code minus 255); codes reset to 255.
// - codes up to 128 (fine) or 154 (wide) mean mute.
// - fine mode 0.5 dB steps to -63; wide mode 1 dB steps to -100.
// - applied level moves one step every 8 sample periods to target.
// - every channel has its own level and applied level; one divider paces all ramps.
// - soft mute set ramps the channel down to mute step by step.
// - soft mute cleared ramps back up to the programmed level.
// - output disable set routes the channel to common voltage.
// - roll-off select 0 sharp, 1 slow; resets to 0.
// - format 0-3 right-justified 24/20/18/16, 4 I2S, 5 left, reset 5.
// - soft reset lasts 1024 clocks and restores every register.
// - zero flags high on zero detect at polarity 0, low at 1.
// - phase invert 0 normal, 1 inverted; resets to 0.
// - de-emphasis rate 00 44.1k, 01 48k, 10 32k; resets 00.
// - de-emphasis enable applies to all channels; resets to 0.
// - attenuation mode resets to 0 fine; 1 selects wide mode.
module dmca_top (
   // ahb-lite slave
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   // sample pacing and zero detect, same clock
   input  wire logic                  sample_tick,
   input  wire logic [1:0]            zero_detect,
   // attenuator state
   output logic [7:0][7:0]            applied_level,
   output logic [7:0][7:0]            atten_half_db,
   output logic [7:0]                 chan_muted,
   output logic [7:0]                 chan_to_common_voltage,
   // mode controls
   output logic                       filter_slow,
   output dmca_pkg::dmca_fmt_t        audio_format,
   output logic [4:0]                 rj_width,
   output logic                       deemph_en,
   output dmca_pkg::dmca_de_t         deemph_rate,
   output logic                       phase_invert,
   output logic [1:0]                 zero_flag,
   output logic                       soft_reset_bit_busy,
   output logic                       irq
);
   import dmca_pkg::*;
   localparam int NC = `DMCA_NCH;
   // {hit, channel} for attenuation register indices
   function automatic logic [3:0] at_chan(input logic [6:0] idx);
      logic [3:0] r;
      r = 4'h0;
      if (idx >= `DMCA_IDX_AT1 && idx <= `DMCA_IDX_AT6)
         r = {1'b1, 3'(idx - `DMCA_IDX_AT1)};
      else if (idx == `DMCA_IDX_AT7)
         r = 4'hE;
      else if (idx == `DMCA_IDX_AT8)
         r = 4'hF;
      return r;
   endfunction
   function automatic logic [7:0] mute_thr(input logic wide);
      return wide ? `DMCA_THR_WIDE : `DMCA_THR_FINE;
   endfunction

   ////////////////////////////////////////////////////////////////////
   logic [7:0][7:0] at_q, at_d, app_q, app_d;
   logic [7:0]      mute_q, mute_d, dis_q, dis_d, stat_q, stat_d;
   logic [7:0]      mask_q, mask_d, done_ev;
   logic            flt_q, flt_d, zero_flag_polarity_q, zero_flag_polarity_d, output_phase_invert_q, output_phase_invert_d;
   logic            dmc_q, dmc_d, attenuation_mode_select_q, attenuation_mode_select_d;
   logic [2:0]      fmt_q, fmt_d, tick_q, tick_d;
   logic [1:0]      dmf_q, dmf_d;
   logic [10:0]     soft_reset_bit_cnt_q, soft_reset_bit_cnt_d;
   dmca_rst_st_t    rst_st;
   logic            wr_pend_q, wr_pend_d, step_en, addr_ok;
   logic [6:0]      widx_q, widx_d, ridx;
   logic [31:0]     rdata_q, rdata_d;
   logic [3:0]      wch, rch;
   assign ridx    = haddr[8:2];
   assign addr_ok = hsel && htrans[1] && hready;
   assign wch     = at_chan(widx_q);
   assign rch     = at_chan(ridx);
   // one shared divider paces all ramps
   assign step_en = sample_tick && (tick_q == `DMCA_RAMP_LAST);
   assign rst_st  = (soft_reset_bit_cnt_q != 11'h000) ? DMCA_SOFT_RESET_BIT : DMCA_RUN;
   always_comb begin
      logic [7:0] tgt, thr;
      tgt        = 8'h00;
      thr        = mute_thr(attenuation_mode_select_q);
      at_d       = at_q;
      app_d      = app_q;
      mute_d     = mute_q;
      dis_d      = dis_q;
      flt_d      = flt_q;
      fmt_d      = fmt_q;
      zero_flag_polarity_d     = zero_flag_polarity_q;
      output_phase_invert_d     = output_phase_invert_q;
      dmf_d      = dmf_q;
      dmc_d      = dmc_q;
      attenuation_mode_select_d     = attenuation_mode_select_q;
      mask_d     = mask_q;
      stat_d     = stat_q;
      done_ev    = 8'h00;
      soft_reset_bit_cnt_d = soft_reset_bit_cnt_q;
      tick_d     = sample_tick ? tick_q + 3'h1 : tick_q;
      wr_pend_d  = addr_ok && hwrite;
      widx_d     = addr_ok ? ridx : widx_q;
      // writes land in the data phase
      if (wr_pend_q && rst_st == DMCA_RUN) begin
         if (wch[3])
            at_d[wch[2:0]] = hwdata[7:0];
         case (widx_q)
            `DMCA_IDX_MUTE_LO: mute_d[5:0] = hwdata[5:0];
            `DMCA_IDX_MUTE_HI: mute_d[7:6] = hwdata[1:0];
            `DMCA_IDX_DIS_LO:  dis_d[5:0]  = hwdata[5:0];
            `DMCA_IDX_DIS_HI:  dis_d[7:6]  = hwdata[1:0];
            `DMCA_IDX_FMT: begin
               flt_d = hwdata[`DMCA_BIT_FLT];
               fmt_d = hwdata[2:0];
            end
            `DMCA_IDX_CTL: begin
               zero_flag_polarity_d = hwdata[`DMCA_BIT_ZERO_FLAG_POLARITY];
               output_phase_invert_d = hwdata[`DMCA_BIT_OUTPUT_PHASE_INVERT];
               dmf_d  = hwdata[`DMCA_MSB_DMF:`DMCA_LSB_DMF];
               dmc_d  = hwdata[`DMCA_BIT_DMC];
               if (hwdata[`DMCA_BIT_SOFT_RESET_BIT])
                  soft_reset_bit_cnt_d = `DMCA_SOFT_RESET_BIT_CYC;
            end
            `DMCA_IDX_MODE: attenuation_mode_select_d = hwdata[`DMCA_BIT_ATTENUATION_MODE_SELECT];
            `DMCA_IDX_MASK: mask_d = hwdata[7:0];
            `DMCA_IDX_STAT: stat_d = stat_q & ~hwdata[7:0];
            default: ;
         endcase
      end
      // per channel ramp toward programmed or mute target
      for (int i = 0; i < NC; i++) begin
         if (mute_q[i] || at_q[i] < thr)
            tgt = thr;
         else
            tgt = at_q[i];
         // steps from where it is, never jumps
         if (step_en && app_q[i] != tgt) begin
            app_d[i] = (app_q[i] < tgt) ? app_q[i] + 8'h01
                                        : app_q[i] - 8'h01;
            done_ev[i] = (app_d[i] == tgt);
         end
      end
      // set wins over write-one-clear
      stat_d = stat_d | done_ev;
      if (rst_st == DMCA_SOFT_RESET_BIT) begin
         soft_reset_bit_cnt_d = soft_reset_bit_cnt_q - 11'h001;
         at_d       = {NC{`DMCA_AT_RST}};
         app_d      = {NC{`DMCA_AT_RST}};
         mute_d     = 8'h00;
         dis_d      = 8'h00;
         flt_d      = 1'b0;
         fmt_d      = `DMCA_FMT_RST;
         zero_flag_polarity_d     = 1'b0;
         output_phase_invert_d     = 1'b0;
         dmf_d      = 2'b00;
         dmc_d      = 1'b0;
         attenuation_mode_select_d     = 1'b0;
         mask_d     = 8'h00;
         stat_d     = 8'h00;
         tick_d     = 3'h0;
      end
      // read data captured in the address phase; no wait states
      rdata_d = 32'h0000_0000;
      if (rch[3])
         rdata_d[7:0] = at_q[rch[2:0]];
      case (ridx)
         `DMCA_IDX_MUTE_LO: rdata_d[5:0] = mute_q[5:0];
         `DMCA_IDX_MUTE_HI: rdata_d[1:0] = mute_q[7:6];
         `DMCA_IDX_DIS_LO:  rdata_d[5:0] = dis_q[5:0];
         `DMCA_IDX_DIS_HI:  rdata_d[1:0] = dis_q[7:6];
         `DMCA_IDX_FMT:  rdata_d[7:0] = {2'b00, flt_q, 2'b00, fmt_q};
         `DMCA_IDX_CTL:  rdata_d[7:0] = {rst_st == DMCA_SOFT_RESET_BIT, zero_flag_polarity_q,
                                         output_phase_invert_q, dmf_q, 2'b00, dmc_q};
         `DMCA_IDX_MODE: rdata_d[7:0] = {attenuation_mode_select_q, 7'h00};
         `DMCA_IDX_STAT: rdata_d[7:0] = stat_q;
         `DMCA_IDX_MASK: rdata_d[7:0] = mask_q;
         `DMCA_IDX_APPL: rdata_d[7:0] = app_q[hwdata[2:0]];
         default: ;
      endcase
      if (!addr_ok || hwrite)
         rdata_d = rdata_q;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         at_q       <= {`DMCA_NCH{`DMCA_AT_RST}};
         app_q      <= {`DMCA_NCH{`DMCA_AT_RST}};
         mute_q     <= 8'h00;
         dis_q      <= 8'h00;
         flt_q      <= 1'b0;
         fmt_q      <= `DMCA_FMT_RST;
         zero_flag_polarity_q     <= 1'b0;
         output_phase_invert_q     <= 1'b0;
         dmf_q      <= 2'b00;
         dmc_q      <= 1'b0;
         attenuation_mode_select_q     <= 1'b0;
         mask_q     <= 8'h00;
         stat_q     <= 8'h00;
         tick_q     <= 3'h0;
         soft_reset_bit_cnt_q <= 11'h000;
         wr_pend_q  <= 1'b0;
         widx_q     <= 7'h00;
         rdata_q    <= 32'h0000_0000;
      end else begin
         at_q       <= at_d;
         app_q      <= app_d;
         mute_q     <= mute_d;
         dis_q      <= dis_d;
         flt_q      <= flt_d;
         fmt_q      <= fmt_d;
         zero_flag_polarity_q     <= zero_flag_polarity_d;
         output_phase_invert_q     <= output_phase_invert_d;
         dmf_q      <= dmf_d;
         dmc_q      <= dmc_d;
         attenuation_mode_select_q     <= attenuation_mode_select_d;
         mask_q     <= mask_d;
         stat_q     <= stat_d;
         tick_q     <= tick_d;
         soft_reset_bit_cnt_q <= soft_reset_bit_cnt_d;
         wr_pend_q  <= wr_pend_d;
         widx_q     <= widx_d;
         rdata_q    <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   logic [7:0][7:0] db_d;
   logic [7:0]      muted_d;
   logic [4:0]      rjw_d;
   always_comb begin
      for (int i = 0; i < NC; i++) begin
         // half-dB units; wide mode doubles the step
         db_d[i] = attenuation_mode_select_q ? 8'((`DMCA_AT_FULL - app_q[i]) << 1)
                          : (`DMCA_AT_FULL - app_q[i]);
         muted_d[i] = app_q[i] <= mute_thr(attenuation_mode_select_q);
      end
      case (dmca_fmt_t'(fmt_q))
         DMCA_RJ24: rjw_d = 5'd24;
         DMCA_RJ20: rjw_d = 5'd20;
         DMCA_RJ18: rjw_d = 5'd18;
         DMCA_RJ16: rjw_d = 5'd16;
         default:   rjw_d = 5'd0;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout     <= 1'b1;
         hrdata        <= 32'h0000_0000;
         hresp         <= 1'b0;
         applied_level <= {`DMCA_NCH{`DMCA_AT_RST}};
         atten_half_db <= 64'h0;
         chan_muted    <= 8'h00;
         chan_to_common_voltage  <= 8'h00;
         filter_slow   <= 1'b0;
         audio_format  <= DMCA_LJ;
         rj_width      <= 5'd0;
         deemph_en     <= 1'b0;
         deemph_rate   <= DMCA_DE_441;
         phase_invert  <= 1'b0;
         zero_flag     <= 2'b00;
         soft_reset_bit_busy     <= 1'b0;
         irq           <= 1'b0;
      end else begin
         hreadyout     <= 1'b1;
         hrdata        <= rdata_d;
         hresp         <= 1'b0;
         applied_level <= app_q;
         atten_half_db <= db_d;
         chan_muted    <= muted_d;
         chan_to_common_voltage  <= dis_q;
         filter_slow   <= flt_q;
         audio_format  <= dmca_fmt_t'(fmt_q);
         rj_width      <= rjw_d;
         deemph_en     <= dmc_q;
         deemph_rate   <= dmca_de_t'(dmf_q);
         phase_invert  <= output_phase_invert_q;
         zero_flag     <= zero_detect ^ {2{zero_flag_polarity_q}};
         soft_reset_bit_busy     <= soft_reset_bit_cnt_d != 11'h000;
         irq           <= |(stat_d & mask_d);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   logic [10:0] busy_len_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         busy_len_q <= 11'h000;
      else
         busy_len_q <= soft_reset_bit_busy ? busy_len_q + 11'h001 : 11'h000;
   end
   property p_soft_reset_bit_len;
      @(posedge hclk) disable iff (!hresetn)
      $fell(soft_reset_bit_busy) |-> busy_len_q == `DMCA_SOFT_RESET_BIT_CYC;
   endproperty
   a_soft_reset_bit_len: assert property (p_soft_reset_bit_len)
      else $error("soft reset not 1024 clocks");
   property p_soft_reset_bit_clear;
      @(posedge hclk) disable iff (!hresetn)
      soft_reset_bit_busy && $past(soft_reset_bit_busy) |->
         fmt_q == `DMCA_FMT_RST && mute_q == 8'h00 && !attenuation_mode_select_q;
   endproperty
   a_soft_reset_bit_clear: assert property (p_soft_reset_bit_clear)
      else $error("registers not reset during soft reset");
   property p_step_pace;
      @(posedge hclk) disable iff (!hresetn)
      app_q != $past(app_q) |-> $past(step_en) || $past(soft_reset_bit_cnt_q != 0);
   endproperty
   a_step_pace: assert property (p_step_pace)
      else $error("level moved off the 8 sample pace");
   property p_step_one;
      @(posedge hclk) disable iff (!hresetn)
      $past(step_en) && $past(soft_reset_bit_cnt_q == 0) |->
         (app_q[0] - $past(app_q[0]) == 8'h01) ||
         ($past(app_q[0]) - app_q[0] == 8'h01) ||
         app_q[0] == $past(app_q[0]);
   endproperty
   a_step_one: assert property (p_step_one)
      else $error("level jumped more than one step");
   property p_mute_down;
      @(posedge hclk) disable iff (!hresetn)
      step_en && mute_q[0] && app_q[0] > mute_thr(attenuation_mode_select_q) && rst_st == DMCA_RUN
         |=> app_q[0] == $past(app_q[0]) - 8'h01;
   endproperty
   a_mute_down: assert property (p_mute_down)
      else $error("soft mute did not step down");
   property p_db_calc;
      @(posedge hclk) disable iff (!hresetn)
      ##1 !$past(attenuation_mode_select_q) |-> atten_half_db[2] == 8'hFF - $past(app_q[2]);
   endproperty
   a_db_calc: assert property (p_db_calc)
      else $error("attenuation value wrong");
   property p_muted;
      @(posedge hclk) disable iff (!hresetn)
      ##1 chan_muted[0] == ($past(app_q[0]) <=
                            ($past(attenuation_mode_select_q) ? `DMCA_THR_WIDE : `DMCA_THR_FINE));
   endproperty
   a_muted: assert property (p_muted)
      else $error("mute decode wrong");
   property p_zero_pol;
      @(posedge hclk) disable iff (!hresetn)
      ##1 zero_flag == ($past(zero_detect) ^ {2{$past(zero_flag_polarity_q)}});
   endproperty
   a_zero_pol: assert property (p_zero_pol)
      else $error("zero flag polarity wrong");
   property p_common_voltage;
      @(posedge hclk) disable iff (!hresetn)
      ##1 chan_to_common_voltage == $past(dis_q) && phase_invert == $past(output_phase_invert_q);
   endproperty
   a_common_voltage: assert property (p_common_voltage)
      else $error("disable or phase output wrong");
endmodule
`default_nettype wire

// ==== testbench/dmca_host.sv ====
// host controller model: single word ahb-lite transfers
`timescale 1ns/1ps
`default_nettype none
module dmca_host (
   // bus answer
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // bus request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [6:0] i,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {23'h0, i, 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      // stale data must not look valid
      hwdata <= ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [6:0] i, input logic [7:0] d);
      logic [31:0] v;
      xfer(1'b1, i, {24'h0, d}, v); // upper bits kept zero
   endtask
   task automatic rd(input logic [6:0] i, output logic [31:0] v);
      xfer(1'b0, i, 32'h0, v);
   endtask
endmodule
`default_nettype wire

// ==== testbench/dac_mode_control_attenuator_tb_top.sv ====
// self-checking bench for mode control and ramped attenuator
`timescale 1ns/1ps
`default_nettype none
`include "dmca_consts.svh"
module dac_mode_control_attenuator_tb_top;
   import dmca_pkg::*;
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic             sample_tick = 1'b0;
   logic [1:0]       zero_detect = 2'h0;
   logic [1:0]       tcnt = 2'h0;
   wire logic        hsel, hwrite, hreadyout, hresp;
   wire logic [31:0] haddr, hwdata, hrdata;
   wire logic [1:0]  htrans, zero_flag;
   wire logic [2:0]  hsize;
   wire logic [7:0][7:0] applied_level, atten_half_db;
   wire logic [7:0]  chan_muted, chan_to_common_voltage;
   wire logic        filter_slow, deemph_en, phase_invert, soft_reset_bit_busy, irq;
   wire logic [4:0]  rj_width;
   dmca_fmt_t        audio_format;
   dmca_de_t         deemph_rate;
   int               miscompares = 0;
   int               cmp_count = 0;
   int               n, k;
   logic [31:0]      rv;
   logic [7:0]       r8;

   always #2 hclk = ~hclk;
   // one sample period every four clocks
   always @(posedge hclk) begin
      tcnt <= tcnt + 2'h1;
      sample_tick <= (tcnt == 2'h3);
   end

   dmca_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .sample_tick(sample_tick),
      .zero_detect(zero_detect), .applied_level(applied_level),
      .atten_half_db(atten_half_db), .chan_muted(chan_muted),
      .chan_to_common_voltage(chan_to_common_voltage), .filter_slow(filter_slow),
      .audio_format(audio_format), .rj_width(rj_width),
      .deemph_en(deemph_en), .deemph_rate(deemph_rate),
      .phase_invert(phase_invert), .zero_flag(zero_flag),
      .soft_reset_bit_busy(soft_reset_bit_busy), .irq(irq));
   dmca_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge hclk);
      #1;
   endtask
   function automatic logic [7:0] half_db(input logic [7:0] c,
                                          input logic wide);
      logic [7:0] d;
      d = 8'hFF - c;
      return wide ? {d[6:0], 1'b0} : d;
   endfunction
   function automatic logic [4:0] rj(input logic [2:0] f);
      case (f)
         3'h0: return 5'h18;
         3'h1: return 5'h14;
         3'h2: return 5'h12;
         3'h3: return 5'h10;
         default: return 5'h00;
      endcase
   endfunction
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200us;
      miscompares++;
      wrap_up();
   end
   initial begin
      rv = $urandom(32'h7d98);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(1);
      for (n = 0; n < 8; n++) begin
         chk(applied_level[n], `DMCA_AT_RST);
         chk(atten_half_db[n], 32'h0);
      end
      chk({filter_slow, chan_to_common_voltage}, 32'h0);
      chk({deemph_en, phase_invert, deemph_rate}, 32'h0);
      chk(audio_format, `DMCA_FMT_RST);
      host.rd(`DMCA_IDX_MODE, rv);
      chk(rv, 32'h0);
      // only defined format codes are sent
      for (n = 0; n < 6; n++) begin
         r8 = {2'h0, 1'($urandom), 2'h0, 3'(n)};
         host.wr(`DMCA_IDX_FMT, r8);
         cyc(2);
         chk(audio_format, n);
         chk(rj_width, rj(3'(n)));
         chk(filter_slow, r8[5]);
      end
      for (n = 0; n < 3; n++) begin
         r8 = {1'b0, 2'($urandom), 2'(n), 2'h0, 1'($urandom)};
         host.wr(`DMCA_IDX_CTL, r8);
         @(posedge hclk);
         zero_detect <= 2'($urandom);
         cyc(3);
         chk(deemph_rate, n);
         chk(deemph_en, r8[0]);
         chk(phase_invert, r8[5]);
         chk(zero_flag, zero_detect ^ {2{r8[6]}});
      end
      r8 = 8'($urandom);
      host.wr(`DMCA_IDX_DIS_LO, {2'h0, r8[5:0]});
      host.wr(`DMCA_IDX_DIS_HI, {6'h0, r8[7:6]});
      cyc(2);
      chk(chan_to_common_voltage, r8);
      host.wr(`DMCA_IDX_AT1 + 7'h2, 8'h81);
      host.wr(`DMCA_IDX_AT1 + 7'h3, 8'h9B);
      host.wr(`DMCA_IDX_AT1, 8'hFD);
      // align to the first step, then time the next one
      for (n = 0; n < 40 && applied_level[0] === 8'hFF; n++) cyc(1);
      chk(applied_level[0], 8'hFE);
      cyc(30);
      chk(applied_level[0], 8'hFE);
      cyc(4);
      chk(applied_level[0], 8'hFD);
      chk(applied_level[1], 8'hFF);
      cyc(127 * 32);
      chk(applied_level[2], 8'h81);
      chk(applied_level[3], 8'h9B);
      chk(atten_half_db[0], half_db(8'hFD, 1'b0));
      chk(atten_half_db[2], half_db(8'h81, 1'b0));
      host.wr(`DMCA_IDX_MUTE_LO, 8'h01);
      host.wr(`DMCA_IDX_MUTE_HI, 8'h02);
      cyc(128 * 32);
      chk(applied_level[0], `DMCA_THR_FINE);
      chk(applied_level[7], `DMCA_THR_FINE);
      chk({chan_muted[7], chan_muted[2], chan_muted[0]}, 3'h5);
      host.wr(`DMCA_IDX_MUTE_LO, 8'h00);
      host.wr(`DMCA_IDX_MUTE_HI, 8'h00);
      cyc(128 * 32);
      chk(applied_level[0], 8'hFD);
      chk(applied_level[7], 8'hFF);
      chk(chan_muted[0], 1'b0);
      host.wr(`DMCA_IDX_MODE, 8'h80);
      cyc(3);
      chk({chan_muted[3], chan_muted[2]}, 2'h1);
      chk(atten_half_db[3], half_db(8'h9B, 1'b1));
      chk(atten_half_db[0], half_db(8'hFD, 1'b1));
      // channel 2 now climbs to the wide threshold
      host.wr(`DMCA_IDX_STAT, 8'hFF);
      host.wr(`DMCA_IDX_MASK, 8'h04);
      cyc(2);
      chk(irq, 1'b0);
      cyc(30 * 32);
      chk(applied_level[2], `DMCA_THR_WIDE);
      chk(irq, 1'b1);
      host.rd(`DMCA_IDX_STAT, rv);
      chk(rv[2], 1'b1);
      host.rd(7'h30, rv);
      chk(rv, 32'h0);
      host.rd(`DMCA_IDX_AT1, rv);
      chk(rv, 32'hFD);
      host.wr(`DMCA_IDX_CTL, 8'h80);
      k = 0;
      // busy rises on the landing edge; look before each wait
      #1;
      for (n = 0; n < 1100; n++) begin
         if (soft_reset_bit_busy === 1'b1) k++;
         cyc(1);
      end
      chk(k, 1024);
      chk({hreadyout, hresp}, 32'h2);
      chk({chan_to_common_voltage, irq, deemph_en}, 32'h0);
      chk(audio_format, `DMCA_FMT_RST);
      chk(applied_level[0], `DMCA_AT_RST);
      host.rd(`DMCA_IDX_MODE, rv);
      chk(rv, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
